// [shared/npic_pkg.sv]
package npic_pkg;
    // source numbering: three timers, two dma channels, four external pins
    localparam int NSRC = 9;
    localparam logic [3:0] SRC_EXT0 = 4'h5;
    localparam logic [3:0] SRC_EXT1 = 4'h6;
    localparam logic [3:0] SRC_NMI = 4'h9;
    localparam int ADDR_W = 8;

    // register byte offsets; control register of source i sits at 4*i
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h24;
    localparam logic [7:0] OFF_INSERV = 8'h28;
    localparam logic [7:0] OFF_PEND = 8'h2C;
    localparam logic [7:0] OFF_EOI = 8'h30;
    localparam logic [7:0] OFF_RELOC = 8'h34;
    localparam logic [7:0] OFF_STAT = 8'h38;

    // field positions
    localparam int F_PRIO_LSB = 0;
    localparam int F_EN = 3;
    localparam int F_CASC = 5;
    localparam int F_EOI_NONSPEC = 15;
    localparam int F_RELOC_SLAVE = 14;
    localparam int F_STAT_SEL = 8;
    localparam int F_STAT_IRQ = 16;

    // values after reset
    localparam logic [2:0] RST_PRIO = 3'h7;
    localparam logic RST_EN = 1'b1;
    localparam logic [8:0] RST_MASK = 9'h1FF;
    localparam logic [31:0] RST_RELOC = 32'h0000_0000;

    // vectors: internal ones are base plus source number
    localparam logic [7:0] VEC_BASE = 8'h20;
    localparam logic [7:0] VEC_NMI = 8'h02;

    // each acknowledge cycle and the gap between them
    localparam int CLK_NS = 50;
    localparam int ACK_NS = 200;
    localparam int ACK_CYC = (ACK_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [2:0] npic_prio_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } npic_wr_s;

    typedef enum {ST_IDLE, ST_REQ, ST_ACK1, ST_GAP, ST_ACK2} npic_state_e;
endpackage

// [hdl/npic_prio_pick.sv]
`timescale 1ns/1ps
`default_nettype none
module npic_prio_pick import npic_pkg::*; #(
    parameter int N = 9
) (
    input wire logic [N-1:0] req,
    input wire npic_prio_t prio [N],
    output logic found,
    output logic [3:0] idx,
    output npic_prio_t level
);
    always_comb begin
        found = 1'b0;
        idx = 4'h0;
        level = 3'h7;
        for (int i = 0; i < N; i++) begin
            // strict compare keeps the lower source number on a tie
            if (req[i] && (!found || prio[i] < level)) begin
                found = 1'b1;
                idx = 4'(i);
                level = prio[i];
            end
        end
    end
endmodule // npic_prio_pick
`default_nettype wire

// [hdl/npic_axil_slave.sv]
`timescale 1ns/1ps
`default_nettype none
module npic_axil_slave import npic_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output npic_wr_s wr,
    output logic [ADDR_W-1:0] wr_addr,
    input wire logic wr_hit,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    npic_wr_s wr_d, wr_q;
    logic aw_rdy_d, aw_rdy_q, w_rdy_d, w_rdy_q, ar_rdy_d, ar_rdy_q;
    logic bvalid_d, bvalid_q, rvalid_d, rvalid_q;
    logic [1:0] bresp_d, bresp_q, rresp_d, rresp_q;
    logic [ADDR_W-1:0] aw_addr_d, aw_addr_q, ar_addr_d, ar_addr_q;
    logic [31:0] w_data_d, w_data_q, rdata_d, rdata_q;
    logic [3:0] w_strb_d, w_strb_q;

    always_comb begin
        aw_rdy_d = aw_rdy_q;
        w_rdy_d = w_rdy_q;
        ar_rdy_d = ar_rdy_q;
        bvalid_d = bvalid_q;
        rvalid_d = rvalid_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        aw_addr_d = aw_addr_q;
        ar_addr_d = ar_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        rdata_d = rdata_q;
        wr_d = '0;
        if (aw_rdy_q && awvalid) begin
            aw_rdy_d = 1'b0;
            aw_addr_d = awaddr;
        end
        if (w_rdy_q && wvalid) begin
            w_rdy_d = 1'b0;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        // address and data may arrive in either order
        if (!aw_rdy_q && !w_rdy_q && !bvalid_q) begin
            wr_d = '{en: wr_hit, addr: aw_addr_q, data: w_data_q,
                     strb: w_strb_q};
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
            aw_rdy_d = 1'b1;
            w_rdy_d = 1'b1;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (ar_rdy_q && arvalid) begin
            ar_rdy_d = 1'b0;
            ar_addr_d = araddr;
        end
        if (!ar_rdy_q && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = rd_hit ? rd_data : 32'h0000_0000;
            rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
            ar_rdy_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
            ar_rdy_q <= 1'b1;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            ar_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            rdata_q <= 32'h0000_0000;
            wr_q <= '0;
        end else begin
            aw_rdy_q <= aw_rdy_d;
            w_rdy_q <= w_rdy_d;
            ar_rdy_q <= ar_rdy_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            aw_addr_q <= aw_addr_d;
            ar_addr_q <= ar_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            rdata_q <= rdata_d;
            wr_q <= wr_d;
        end
    end

    assign awready = aw_rdy_q;
    assign wready = w_rdy_q;
    assign arready = ar_rdy_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;
    assign wr = wr_q;
    assign wr_addr = aw_addr_q;
    assign rd_addr = ar_addr_q;
endmodule // npic_axil_slave
`default_nettype wire

// [hdl/npic_ctrl.sv]
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module npic_ctrl import npic_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] timer_req,
    input wire logic [1:0] dma_req,
    input wire logic nmi_pin,
    input wire logic [3:0] ext_pin,
    input wire logic [7:0] casc_vec_pin,
    input wire logic cpu_int_en,
    input wire logic cpu_ack,
    output logic cpu_irq,
    output logic [7:0] cpu_vector,
    output logic cpu_vec_valid,
    output logic [1:0] req_ack_cyc,
    output logic [1:0] req_ack_cyc_oe
);
    npic_wr_s wr;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] rd_data;
    logic wr_hit, rd_hit;

    npic_prio_t prio_d [NSRC];
    npic_prio_t prio_q [NSRC];
    logic [NSRC-1:0] en_d, en_q, mask_d, mask_q;
    logic [NSRC-1:0] pend_d, pend_q, is_d, is_q;
    logic [1:0] casc_d, casc_q;
    logic [31:0] reloc_d, reloc_q;
    logic nmi_pend_d, nmi_pend_q;
    npic_state_e state_d, state_q;
    logic [3:0] sel_d, sel_q;
    logic [2:0] cnt_d, cnt_q;
    logic irq_d, irq_q, vvalid_d, vvalid_q;
    logic [7:0] vec_d, vec_q;
    logic [1:0] ack_d, ack_q, ack_oe_d, ack_oe_q;

    // pin synchronisers; stage 1 feeds stage 2 only
    logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [7:0] vec_s1_q, vec_s2_q;

    logic slave_mode;
    logic [NSRC-1:0] raw_req, eligible, ext_ok;
    logic [4:0] pin_rise;
    logic win_found, is_found;
    logic [3:0] win_idx, is_idx;
    npic_prio_t is_lvl;
    logic [5:0] wr_idx, rd_idx;
    logic [31:0] bmask;
    logic [31:0] ctrl_new;
    logic lane;
    logic is_cascade_sel;

    npic_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr(wr),
        .wr_addr(wr_addr),
        .wr_hit(wr_hit),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    assign slave_mode = reloc_q[F_RELOC_SLAVE];
    assign pin_rise = pin_s2_q & ~pin_s3_q;

    // in slave mode the external master owns the pins, so they are ignored;
    // a pin turned into an acknowledge line can raise no request
    assign ext_ok = {~casc_q[1], ~casc_q[0], 2'b11, 5'b0_0000}
                    & {NSRC{~slave_mode}};
    assign raw_req = {pin_rise[3:0], dma_req, timer_req} & en_q
                     & (ext_ok | {4'h0, 5'h1F});

    npic_prio_pick #(.N(NSRC)) u_is_pick (
        .req(is_q),
        .prio(prio_q),
        .found(is_found),
        .idx(is_idx),
        .level(is_lvl)
    );

    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            // strictly higher than every source in service
            eligible[i] = pend_q[i] && !mask_q[i] && !is_q[i]
                && (!is_found || prio_q[i] < is_lvl)
                && cpu_int_en;
        end
    end

    npic_prio_pick #(.N(NSRC)) u_win_pick (
        .req(eligible),
        .prio(prio_q),
        .found(win_found),
        .idx(win_idx),
        .level()
    );

    // write and read decoding
    assign wr_idx = wr_addr[7:2];
    assign rd_idx = rd_addr[7:2];
    assign wr_hit = (wr_idx < 6'(NSRC)) || wr_addr == OFF_MASK
                    || wr_addr == OFF_INSERV || wr_addr == OFF_PEND
                    || wr_addr == OFF_EOI || wr_addr == OFF_RELOC
                    || wr_addr == OFF_STAT;
    assign rd_hit = (rd_idx < 6'(NSRC)) || rd_addr == OFF_MASK
                    || rd_addr == OFF_INSERV || rd_addr == OFF_PEND
                    || rd_addr == OFF_EOI || rd_addr == OFF_RELOC
                    || rd_addr == OFF_STAT;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_idx < 6'(NSRC)) begin
            rd_data[F_PRIO_LSB +: 3] = prio_q[rd_idx[3:0]];
            rd_data[F_EN] = en_q[rd_idx[3:0]];
            if (rd_idx == 6'(SRC_EXT0)) begin
                rd_data[F_CASC] = casc_q[0];
            end
            if (rd_idx == 6'(SRC_EXT1)) begin
                rd_data[F_CASC] = casc_q[1];
            end
        end else begin
            case (rd_addr)
                OFF_MASK: rd_data[NSRC-1:0] = mask_q;
                OFF_INSERV: rd_data[NSRC-1:0] = is_q;
                OFF_PEND: rd_data[NSRC-1:0] = pend_q;
                OFF_RELOC: rd_data = reloc_q;
                OFF_STAT: begin
                    rd_data[7:0] = vec_q;
                    rd_data[F_STAT_SEL +: 4] = sel_q;
                    rd_data[F_STAT_IRQ] = irq_q;
                end
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[8*b +: 8] = {8{wr.strb[b]}};
        end
    end

    assign is_cascade_sel = (sel_q == SRC_EXT0 && casc_q[0])
                            || (sel_q == SRC_EXT1 && casc_q[1]);
    assign lane = (sel_q == SRC_EXT1);

    always_comb begin
        prio_d = prio_q;
        en_d = en_q;
        mask_d = mask_q;
        casc_d = casc_q;
        reloc_d = reloc_q;
        is_d = is_q;
        state_d = state_q;
        sel_d = sel_q;
        cnt_d = cnt_q;
        irq_d = irq_q;
        vec_d = vec_q;
        vvalid_d = 1'b0;
        ctrl_new = 32'h0000_0000;

        // software side first, so a same-cycle set below wins
        if (wr.en && wr_idx < 6'(NSRC)) begin
            ctrl_new[F_PRIO_LSB +: 3] = prio_q[wr_idx[3:0]];
            ctrl_new[F_EN] = en_q[wr_idx[3:0]];
            ctrl_new = (ctrl_new & ~bmask) | (wr.data & bmask);
            prio_d[wr_idx[3:0]] = ctrl_new[F_PRIO_LSB +: 3];
            en_d[wr_idx[3:0]] = ctrl_new[F_EN];
            if (wr_idx == 6'(SRC_EXT0) && wr.strb[0]) begin
                casc_d[0] = wr.data[F_CASC];
            end
            if (wr_idx == 6'(SRC_EXT1) && wr.strb[0]) begin
                casc_d[1] = wr.data[F_CASC];
            end
        end
        if (wr.en && wr_addr == OFF_MASK) begin
            mask_d = (mask_q & ~bmask[NSRC-1:0])
                     | (wr.data[NSRC-1:0] & bmask[NSRC-1:0]);
        end
        if (wr.en && wr_addr == OFF_RELOC) begin
            reloc_d = (reloc_q & ~bmask) | (wr.data & bmask);
        end
        if (wr.en && wr_addr == OFF_EOI) begin
            if (wr.data[F_EOI_NONSPEC]) begin
                // non-specific end clears the highest source in service
                if (is_found) begin
                    is_d[is_idx] = 1'b0;
                end
            end else if (wr.data[3:0] < 4'(NSRC)) begin
                is_d[wr.data[3:0]] = 1'b0;
            end
        end

        // pending requests latch; acknowledge clears, a new one wins
        pend_d = pend_q;
        nmi_pend_d = nmi_pend_q;

        case (state_q)
            ST_IDLE: begin
                if (nmi_pend_q) begin
                    state_d = ST_REQ;
                    irq_d = 1'b1;
                    sel_d = SRC_NMI;
                end else if (win_found) begin
                    state_d = ST_REQ;
                    irq_d = 1'b1;
                    sel_d = win_idx;
                end
            end
            ST_REQ: begin
                if (cpu_ack) begin
                    irq_d = 1'b0;
                    state_d = ST_IDLE;
                    if (sel_q == SRC_NMI) begin
                        nmi_pend_d = 1'b0;
                        vec_d = VEC_NMI;
                        vvalid_d = 1'b1;
                    end else begin
                        pend_d[sel_q] = 1'b0;
                        is_d[sel_q] = 1'b1;
                        if (is_cascade_sel) begin
                            state_d = ST_ACK1;
                            cnt_d = 3'(ACK_CYC - 1);
                        end else begin
                            vec_d = VEC_BASE + {4'h0, sel_q};
                            vvalid_d = 1'b1;
                        end
                    end
                end else if (nmi_pend_q) begin
                    sel_d = SRC_NMI;
                end else if (win_found) begin
                    // a newly arrived higher request replaces the offer
                    sel_d = win_idx;
                end else begin
                    irq_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            ST_ACK1: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h0) begin
                    state_d = ST_GAP;
                    cnt_d = 3'(ACK_CYC - 1);
                end
            end
            ST_GAP: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h0) begin
                    state_d = ST_ACK2;
                    cnt_d = 3'(ACK_CYC - 1);
                end
            end
            ST_ACK2: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h0) begin
                    // sampled at the end so the bus has settled
                    state_d = ST_IDLE;
                    vec_d = vec_s2_q;
                    vvalid_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                irq_d = 1'b0;
            end
        endcase

        pend_d = pend_d | raw_req;
        if (pin_rise[4]) begin
            nmi_pend_d = 1'b1;
        end

        ack_d = 2'b00;
        if (state_d == ST_ACK1 || state_d == ST_ACK2) begin
            ack_d = lane ? 2'b10 : 2'b01;
        end
        ack_oe_d = casc_d & {2{~reloc_d[F_RELOC_SLAVE]}};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
            vec_s1_q <= 8'h00;
            vec_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= {nmi_pin, ext_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            vec_s1_q <= casc_vec_pin;
            vec_s2_q <= vec_s1_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NSRC; i++) begin
                prio_q[i] <= RST_PRIO;
            end
            en_q <= {NSRC{RST_EN}};
            mask_q <= RST_MASK;
            casc_q <= 2'b00;
            reloc_q <= RST_RELOC;
            pend_q <= '0;
            is_q <= '0;
            nmi_pend_q <= 1'b0;
            state_q <= ST_IDLE;
            sel_q <= 4'h0;
            cnt_q <= 3'h0;
            irq_q <= 1'b0;
            vec_q <= 8'h00;
            vvalid_q <= 1'b0;
            ack_q <= 2'b00;
            ack_oe_q <= 2'b00;
        end else begin
            prio_q <= prio_d;
            en_q <= en_d;
            mask_q <= mask_d;
            casc_q <= casc_d;
            reloc_q <= reloc_d;
            pend_q <= pend_d;
            is_q <= is_d;
            nmi_pend_q <= nmi_pend_d;
            state_q <= state_d;
            sel_q <= sel_d;
            cnt_q <= cnt_d;
            irq_q <= irq_d;
            vec_q <= vec_d;
            vvalid_q <= vvalid_d;
            ack_q <= ack_d;
            ack_oe_q <= ack_oe_d;
        end
    end

    assign cpu_irq = irq_q;
    assign cpu_vector = vec_q;
    assign cpu_vec_valid = vvalid_q;
    assign req_ack_cyc = ack_q;
    assign req_ack_cyc_oe = ack_oe_q;
endmodule // npic_ctrl
`default_nettype wire

// [tb/npic_ext_model.sv]
`timescale 1ns/1ps
`default_nettype none
module npic_ext_model import npic_pkg::*; (
    input wire logic aclk,
    input wire logic [1:0] req_ack_cyc,
    input wire logic [1:0] req_ack_cyc_oe,
    input wire logic [3:0] ext_req,
    input wire logic [7:0] vec0,
    input wire logic [7:0] vec1,
    output logic [3:0] ext_pin,
    output logic [7:0] casc_vec_pin
);
    logic [1:0] nth = 2'h0;
    logic [1:0] prev = 2'h0;
    // a driven pin shows the ack level, not the request
    assign ext_pin[2] = req_ack_cyc_oe[0] ? req_ack_cyc[0] : ext_req[2];
    assign ext_pin[3] = req_ack_cyc_oe[1] ? req_ack_cyc[1] : ext_req[3];
    assign ext_pin[1:0] = ext_req[1:0];
    initial casc_vec_pin = 8'h00;
    // released bus toggles so a stale vector never looks right
    always @(posedge aclk) begin
        for (int k = 0; k < 2; k++)
            if (req_ack_cyc[k] && !prev[k]) nth[k] = ~nth[k];
        prev <= req_ack_cyc;
        if (req_ack_cyc[0] && !nth[0]) casc_vec_pin <= vec0;
        else if (req_ack_cyc[1] && !nth[1]) casc_vec_pin <= vec1;
        else casc_vec_pin <= ~casc_vec_pin;
    end
endmodule // npic_ext_model
`default_nettype wire

// [tb/npic_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module npic_checker import npic_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic nmi_pin,
    input wire logic cpu_ack,
    input wire logic cpu_irq,
    input wire logic [7:0] cpu_vector,
    input wire logic cpu_vec_valid,
    input wire logic [1:0] req_ack_cyc,
    input wire logic [1:0] req_ack_cyc_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_vv;
        cpu_vec_valid |=> !cpu_vec_valid;
    endproperty
    a_vv: assert property (p_vv)
        else $error("vector strobe too long");
    property p_drop;
        cpu_irq && cpu_ack |=> !cpu_irq;
    endproperty
    a_drop: assert property (p_drop)
        else $error("request kept after ack");
    property p_pair0;
        $rose(req_ack_cyc[0]) && $past(cpu_irq) |-> req_ack_cyc[0] [*4]
        ##1 (!req_ack_cyc[0]) [*4] ##1 req_ack_cyc[0] [*4]
        ##1 !req_ack_cyc[0] ##[0:1] cpu_vec_valid;
    endproperty
    a_pair0: assert property (p_pair0)
        else $error("pair0 ack cycles wrong");
    property p_pair1;
        $rose(req_ack_cyc[1]) && $past(cpu_irq) |-> req_ack_cyc[1] [*4]
        ##1 (!req_ack_cyc[1]) [*4] ##1 req_ack_cyc[1] [*4];
    endproperty
    a_pair1: assert property (p_pair1)
        else $error("pair1 ack cycles wrong");
    property p_oe;
        (req_ack_cyc & ~req_ack_cyc_oe) == 2'h0;
    endproperty
    a_oe: assert property (p_oe)
        else $error("ack without drive enable");
    property p_nmi;
        $rose(nmi_pin) && !cpu_irq |-> ##[1:20] cpu_irq;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("nmi not offered");
    property p_vec;
        cpu_vec_valid && $past(req_ack_cyc) == 2'h0
        && $past(req_ack_cyc, 2) == 2'h0 |-> cpu_vector == VEC_NMI
        || (cpu_vector >= VEC_BASE && cpu_vector < VEC_BASE + NSRC);
    endproperty
    a_vec: assert property (p_vec)
        else $error("internal vector out of range");
    property p_idle;
        cpu_ack && !cpu_irq && !cpu_vec_valid && req_ack_cyc == 2'h0
        && $past(req_ack_cyc) == 2'h0 |=> !cpu_vec_valid;
    endproperty
    a_idle: assert property (p_idle)
        else $error("stray ack served");
endmodule // npic_checker
bind npic_ctrl npic_checker chk_u (.*);
`default_nettype wire

// [tb/nested_priority_interrupt_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module nested_priority_interrupt_ctrl_bench import npic_pkg::*; ;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, cpu_irq, cpu_vec_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, req_ack_cyc, req_ack_cyc_oe;
    logic [2:0] timer_req = 3'h0;
    logic [1:0] dma_req = 2'h0;
    logic nmi_pin = 1'b0, cpu_int_en = 1'b1, cpu_ack = 1'b0;
    logic [7:0] cpu_vector, casc_vec_pin, vec0 = 8'h00, vec1 = 8'h00;
    logic [3:0] ext_pin, ext_req = 4'h0;
    int error_cnt = 0, check_count = 0;
    npic_ctrl dut_u (.*, .s_axi_wstrb(4'hF));
    npic_ext_model ext_u (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(a > OFF_STAT ? RESP_SLVERR : RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(a > OFF_STAT ? RESP_SLVERR : RESP_OKAY));
    endtask
    task automatic pulse(input logic [2:0] t, input logic [1:0] d);
        @(posedge aclk);
        timer_req <= t;
        dma_req <= d;
        repeat (2) @(posedge aclk);
        timer_req <= 3'h0;
        dma_req <= 2'h0;
    endtask
    // the core acks on the edge after it sees the request
    task automatic serve(input logic [7:0] v);
        do @(posedge aclk); while (!cpu_irq);
        cpu_ack <= 1'b1;
        @(posedge aclk);
        cpu_ack <= 1'b0;
        do @(posedge aclk); while (!cpu_vec_valid);
        chk(32'({cpu_vec_valid, cpu_vector}), 32'({1'b1, v}));
    endtask
    task automatic quiet();
        logic seen = 1'b0;
        cpu_ack <= 1'b1;
        repeat (30) begin
            @(posedge aclk);
            cpu_ack <= 1'b0;
            seen = seen | cpu_irq;
        end
        chk(32'(seen), 32'h0);
    endtask
    task automatic t_reset();
        for (int i = 0; i < NSRC; i++) rd(8'(4 * i), 32'h0000_000F);
        rd(OFF_MASK, 32'(RST_MASK));
        rd(OFF_RELOC, RST_RELOC);
        rd(8'h3C, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_prio();
        wr(OFF_MASK, 32'h0);
        wr(OFF_CTRL0, 32'h0000_000D);
        wr(8'h0C, 32'h0000_000B);
        pulse(3'h1, 2'h1);
        serve(8'h23);
        rd(OFF_INSERV, 32'h0000_0008);
        quiet();
        wr(OFF_EOI, 32'h3);
        serve(8'h20);
        wr(8'h10, 32'h0000_000A);
        pulse(3'h0, 2'h2);
        serve(8'h24);
        pulse(3'h1, 2'h0);
        wr(OFF_EOI, 32'h4);
        quiet();
        wr(OFF_EOI, 32'h8000);
        serve(8'h20);
        wr(OFF_EOI, 32'h8000);
        $display("test prio done");
    endtask
    task automatic t_tie();
        pulse(3'h6, 2'h0);
        serve(8'h21);
        wr(OFF_EOI, 32'h1);
        serve(8'h22);
        wr(OFF_EOI, 32'h2);
        $display("test tie done");
    endtask
    task automatic t_mask();
        wr(8'h08, 32'h7);
        wr(OFF_MASK, 32'h2);
        pulse(3'h6, 2'h0);
        quiet();
        wr(OFF_MASK, 32'h0);
        serve(8'h21);
        wr(OFF_EOI, 32'h1);
        quiet();
        wr(8'h08, 32'hF);
        cpu_int_en <= 1'b0;
        pulse(3'h1, 2'h0);
        quiet();
        nmi_pin <= 1'b1;
        serve(VEC_NMI);
        nmi_pin <= 1'b0;
        cpu_int_en <= 1'b1;
        serve(8'h20);
        wr(OFF_EOI, 32'h0);
        $display("test mask done");
    endtask
    task automatic t_ext();
        ext_req <= 4'h1;
        serve(8'h25);
        ext_req <= 4'h0;
        wr(OFF_EOI, 32'h5);
        wr(8'h14, 32'h2F);
        vec0 <= 8'hA5;
        ext_req <= 4'h1;
        serve(8'hA5);
        wr(OFF_EOI, 32'h5);
        wr(8'h18, 32'h2F);
        vec1 <= 8'h5A;
        ext_req <= 4'h2;
        serve(8'h5A);
        ext_req <= 4'h0;
        wr(OFF_EOI, 32'h6);
        pulse(3'h1, 2'h0);
        serve(8'h20);
        wr(OFF_EOI, 32'h0);
        wr(OFF_RELOC, 32'h4000);
        ext_req <= 4'h2;
        quiet();
        $display("test ext done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial forever #25 aclk = ~aclk;
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_prio();
        t_tie();
        t_mask();
        t_ext();
        finish_test();
    end
    // well under 1000 cycles expected; twenty times that means a hang
    initial begin
        #1000000;
        error_cnt++;
        finish_test();
    end
endmodule // nested_priority_interrupt_ctrl_bench
`default_nettype wire
